//--- erb_fabric_parity.sv
// Purpose: Fabric logic model that builds stored words with parity bits.
// Assumes: Four eight-bit payload bytes, one parity bit above each.
// Notes:   Purely combinational; the RAM block only stores the result.
`timescale 1ns/1ps
`default_nettype none

module erb_fabric_parity (
	input  wire logic [31:0]         payload,
	output var  erb_pkg::erb_a_word_t stored
);
	////////////////////////////////////////////////////////////////////////
	// Fabric owns all control.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			stored[9*i +: 8] = payload[8*i +: 8];
			stored[9*i+8] = ^payload[8*i +: 8];
		end
	end
endmodule
`default_nettype wire

//--- erb_map.svh
// Purpose: Constants of the embedded RAM block.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Port A is 128 x 36, port B is 256 x 18, nine-bit bytes.
`ifndef ERB_MAP_SVH
`define ERB_MAP_SVH

`define ERB_DATA_BITS   4096
`define ERB_TOTAL_BITS  4608
`define ERB_WORDS       128
`define ERB_BYTE_W      9
`define ERB_A_W         36
`define ERB_A_AW        7
`define ERB_A_BE        4
`define ERB_B_W         18
`define ERB_B_AW        8
`define ERB_B_BE        2
`define ERB_A_BE_RST    4'hF
`define ERB_B_BE_RST    2'h3
`define ERB_INIT_SEED   36'h000000000
`define ERB_CLK_NS      25

`endif

//--- erb_mem_array.sv
// Purpose: Storage array of the RAM block with two registered read ports.
// Assumes: Inputs come from registers; en is the block clock enable.
// Notes:   Port A is 36 bits wide, port B 18 bits, over one array.
`timescale 1ns/1ps
`default_nettype none
`include "erb_map.svh"

module erb_mem_array (
	input  wire logic                 mclk,
	input  wire logic                 clr,
	input  wire logic                 en,
	input  wire logic                 aWe,
	input  wire erb_pkg::erb_a_be_t   aBe,
	input  wire erb_pkg::erb_a_addr_t aAddr,
	input  wire erb_pkg::erb_a_word_t aWd,
	input  wire logic                 bWe,
	input  wire erb_pkg::erb_b_be_t   bBe,
	input  wire erb_pkg::erb_b_addr_t bAddr,
	input  wire erb_pkg::erb_b_word_t bWd,
	output var  erb_pkg::erb_a_word_t aQ,
	output var  erb_pkg::erb_b_word_t bQ
);

	erb_pkg::erb_a_word_t mem [`ERB_WORDS];
	erb_pkg::erb_a_word_t aOld;
	erb_pkg::erb_a_word_t aNew;
	erb_pkg::erb_a_word_t bBase;
	erb_pkg::erb_a_word_t bNew;
	erb_pkg::erb_a_addr_t bWord;
	erb_pkg::erb_b_word_t bOldHalf;
	logic                 sameWord;

	////////////////////////////////////////////////////////////////////////
	// Preloaded image.
	initial begin
		for (int i = 0; i < `ERB_WORDS; i++) begin
			mem[i] = `ERB_INIT_SEED ^ 36'(i);
		end
	end

	assign bWord    = bAddr[`ERB_B_AW-1:1];
	assign sameWord = (bWord == aAddr);
	assign aOld     = mem[aAddr];
	assign bBase    = (aWe && sameWord) ? aNew : mem[bWord];
	assign bOldHalf = bAddr[0] ? mem[bWord][`ERB_A_W-1:`ERB_B_W]
		: mem[bWord][`ERB_B_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Byte lane masking.
	for (genvar i = 0; i < `ERB_A_BE; i++) begin : gByte
		localparam int LO = i * `ERB_BYTE_W;
		localparam int HALF = i / `ERB_B_BE;
		localparam int LANE = i % `ERB_B_BE;
		assign aNew[LO +: `ERB_BYTE_W] = aBe[i] ? aWd[LO +: `ERB_BYTE_W]
			: aOld[LO +: `ERB_BYTE_W];
		assign bNew[LO +: `ERB_BYTE_W] =
			(bAddr[0] == HALF[0] && bBe[LANE])
			? bWd[LANE*`ERB_BYTE_W +: `ERB_BYTE_W]
			: bBase[LO +: `ERB_BYTE_W];
	end

	////////////////////////////////////////////////////////////////////////
	// Two ports act at once.
	always_ff @(posedge mclk) begin
		if (en) begin
			if (aWe) begin
				mem[aAddr] <= aNew;
			end
			if (bWe) begin
				mem[bWord] <= bNew;
			end
		end
		if (clr) begin
			aQ <= '0;
			bQ <= '0;
		end else if (en) begin
			aQ <= aWe ? aNew : aOld;
			bQ <= bWe ? (bAddr[0] ? bNew[`ERB_A_W-1:`ERB_B_W]
				: bNew[`ERB_B_W-1:0]) : bOldHalf;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_mixed_old_b: assert property (@(posedge mclk) disable iff (clr)
		(en && aWe && !bWe && sameWord) |=> bQ == $past(bOldHalf))
		else $error("Port B did not return old data on collision.");

	a_byte_masked: assert property (@(posedge mclk) disable iff (clr)
		(en && aWe && !aBe[0] && !bWe) |=> aQ[8:0] == $past(aOld[8:0]))
		else $error("Masked byte was changed.");

endmodule
`default_nettype wire

//--- erb_pkg.sv
// Purpose: Types shared by the embedded RAM block files.
// Assumes: Constants come from the map header.
// Notes:   Types only, no logic.
`include "erb_map.svh"

package erb_pkg;
	typedef logic [`ERB_A_W-1:0]  erb_a_word_t;
	typedef logic [`ERB_A_AW-1:0] erb_a_addr_t;
	typedef logic [`ERB_A_BE-1:0] erb_a_be_t;
	typedef logic [`ERB_B_W-1:0]  erb_b_word_t;
	typedef logic [`ERB_B_AW-1:0] erb_b_addr_t;
	typedef logic [`ERB_B_BE-1:0] erb_b_be_t;
	typedef logic [`ERB_BYTE_W-1:0] erb_byte_t;
endpackage

//--- erb_ram_block.sv
// Purpose: Embedded true dual-port RAM block with registered inputs.
// Assumes: User fabric logic drives all inputs on mclk at 40 MHz.
// Notes:   Flow-through data after two edges, pipelined after three.
//
// Notes on behaviour
// - The array stores 4,096 data bits, 4,608 with the ninth bit per byte.
// - Both ports work at once: read plus write, two reads or two writes.
// - Byte enables mask the write so only enabled bytes are stored.
// - The array starts from a preloaded image, never undefined contents.
// - A port reading the address it writes shows the new data.
// - A port reading an address the other port writes shows old data.
// - The clock enable stops every read, write and register update other than the clears.
// - Input registers have no asynchronous clear and change only on edges.
// - The output clear zeroes the output registers at once, no edge needed.
// - Registers clear only by power-up, the output clear or chip clear.
// - The two ports have different widths, 36 and 18 bits.
// - The ninth bit of each byte is plain storage for any use.
// - Inputs are registered; read data leaves registered or flow-through.
// - Byte enables default to all asserted.
`timescale 1ns/1ps
`default_nettype none
`include "erb_map.svh"

module erb_ram_block (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 chip_wide_clear_n,
	input  wire logic                 outAclr,
	input  wire logic                 clkEn,
	input  wire logic                 romMode,
	input  wire erb_pkg::erb_a_addr_t aAddr,
	input  wire erb_pkg::erb_a_word_t aWrData,
	input  wire logic                 aWrEn,
	input  wire erb_pkg::erb_a_be_t   aByteEn,
	input  wire erb_pkg::erb_b_addr_t bAddr,
	input  wire erb_pkg::erb_b_word_t bWrData,
	input  wire logic                 bWrEn,
	input  wire erb_pkg::erb_b_be_t   bByteEn,
	output var  erb_pkg::erb_a_word_t aFlowData,
	output var  erb_pkg::erb_a_word_t aPipeData,
	output var  erb_pkg::erb_b_word_t bFlowData,
	output var  erb_pkg::erb_b_word_t bPipeData
);

	logic                 clr;
	erb_pkg::erb_a_addr_t aAddr_r;
	erb_pkg::erb_a_addr_t aAddr_nxt;
	erb_pkg::erb_a_word_t aData_r;
	erb_pkg::erb_a_word_t aData_nxt;
	logic                 aWe_r;
	logic                 aWe_nxt;
	erb_pkg::erb_a_be_t   aBe_r;
	erb_pkg::erb_a_be_t   aBe_nxt;
	erb_pkg::erb_b_addr_t bAddr_r;
	erb_pkg::erb_b_addr_t bAddr_nxt;
	erb_pkg::erb_b_word_t bData_r;
	erb_pkg::erb_b_word_t bData_nxt;
	logic                 bWe_r;
	logic                 bWe_nxt;
	erb_pkg::erb_b_be_t   bBe_r;
	erb_pkg::erb_b_be_t   bBe_nxt;
	logic                 rom_r;
	logic                 rom_nxt;
	erb_pkg::erb_a_word_t aPipe_r;
	erb_pkg::erb_a_word_t aPipe_nxt;
	erb_pkg::erb_b_word_t bPipe_r;
	erb_pkg::erb_b_word_t bPipe_nxt;
	erb_pkg::erb_a_word_t aQ;
	erb_pkg::erb_b_word_t bQ;

	////////////////////////////////////////////////////////////////////////
	// Power-up and chip clear.
	assign clr = reset || !chip_wide_clear_n;

	////////////////////////////////////////////////////////////////////////
	// Input registers.
	always_comb begin
		aAddr_nxt = aAddr_r;
		aData_nxt = aData_r;
		aWe_nxt   = aWe_r;
		aBe_nxt   = aBe_r;
		bAddr_nxt = bAddr_r;
		bData_nxt = bData_r;
		bWe_nxt   = bWe_r;
		bBe_nxt   = bBe_r;
		rom_nxt   = rom_r;
		if (clr) begin
			aWe_nxt = 1'b0;
			bWe_nxt = 1'b0;
			aBe_nxt = `ERB_A_BE_RST;
			bBe_nxt = `ERB_B_BE_RST;
			rom_nxt = 1'b0;
		end else if (clkEn) begin
			aAddr_nxt = aAddr;
			aData_nxt = aWrData;
			aWe_nxt   = aWrEn;
			aBe_nxt   = aByteEn;
			bAddr_nxt = bAddr;
			bData_nxt = bWrData;
			bWe_nxt   = bWrEn;
			bBe_nxt   = bByteEn;
			rom_nxt   = romMode;
		end
	end

	always_ff @(posedge mclk) begin
		aAddr_r <= aAddr_nxt;
		aData_r <= aData_nxt;
		aWe_r   <= aWe_nxt;
		aBe_r   <= aBe_nxt;
		bAddr_r <= bAddr_nxt;
		bData_r <= bData_nxt;
		bWe_r   <= bWe_nxt;
		bBe_r   <= bBe_nxt;
		rom_r   <= rom_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Storage array of 128 words of 36 bits.
	// Array of 4,608 bits.
	erb_mem_array uArray (
		.mclk  (mclk),
		.clr   (clr),
		.en    (clkEn),
		.aWe   (aWe_r && !rom_r),
		.aBe   (aBe_r),
		.aAddr (aAddr_r),
		.aWd   (aData_r),
		.bWe   (bWe_r && !rom_r),
		.bBe   (bBe_r),
		.bAddr (bAddr_r),
		.bWd   (bData_r),
		.aQ    (aQ),
		.bQ    (bQ)
	);

	assign aFlowData = aQ;
	assign bFlowData = bQ;

	////////////////////////////////////////////////////////////////////////
	// Output registers.
	always_comb begin
		aPipe_nxt = aPipe_r;
		bPipe_nxt = bPipe_r;
		if (clr) begin
			aPipe_nxt = '0;
			bPipe_nxt = '0;
		end else if (clkEn) begin
			aPipe_nxt = aQ;
			bPipe_nxt = bQ;
		end
	end

	always_ff @(posedge mclk or posedge outAclr) begin
		if (outAclr) begin
			aPipe_r <= '0;
			bPipe_r <= '0;
		end else begin
			aPipe_r <= aPipe_nxt;
			bPipe_r <= bPipe_nxt;
		end
	end

	assign aPipeData = aPipe_r;
	assign bPipeData = bPipe_r;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	a_aclr_zero: assert property (@(posedge mclk) disable iff (reset)
		outAclr |-> (aPipeData == '0 && bPipeData == '0))
		else $error("Output clear did not zero the output registers.");

	a_clken_hold: assert property (@(posedge mclk) disable iff (reset)
		(!clkEn && !clr) ##1 !outAclr |-> $stable(aFlowData)
		&& $stable(bFlowData) && $stable(aPipeData) && $stable(bPipeData))
		else $error("Block changed while the clock enable was low.");

	a_inreg_hold: assert property (@(posedge mclk) disable iff (reset)
		(!clkEn && !clr) |=> $stable(aAddr_r) && $stable(aData_r)
		&& $stable(aWe_r) && $stable(bAddr_r) && $stable(bBe_r))
		else $error("Input register moved without an enabled edge.");

	a_same_new_a: assert property (@(posedge mclk) disable iff (clr)
		(clkEn && aWe_r && !rom_r && aBe_r == `ERB_A_BE_RST && !bWe_r)
		|=> aFlowData == $past(aData_r))
		else $error("Port A read-during-write did not show new data.");

	a_clear_outs: assert property (@(posedge mclk)
		(clr && !outAclr) |=> (aFlowData == '0 && bFlowData == '0
		&& aPipeData == '0 && bPipeData == '0))
		else $error("Clear did not zero the read registers.");

	a_be_default: assert property (@(posedge mclk)
		clr |=> (aBe_r == `ERB_A_BE_RST && bBe_r == `ERB_B_BE_RST))
		else $error("Byte enables did not default to asserted.");

	a_pipe_stage: assert property (@(posedge mclk) disable iff (clr)
		(clkEn && !clr) ##1 !outAclr |-> aPipeData == $past(aFlowData, 1))
		else $error("Pipelined output did not follow flow data.");

	a_rom_hold: assert property (@(posedge mclk) disable iff (clr)
		(clkEn && rom_r && aWe_r && aAddr_r == bAddr_r[7:1] && !bWe_r
		&& bAddr_r[0] == 1'b0) ##1 (clkEn && aAddr_r == $past(aAddr_r)
		&& !aWe_r) |=> aFlowData == $past(aFlowData))
		else $error("Write reached the array in ROM use.");

	a_two_writes: assert property (@(posedge mclk) disable iff (clr)
		(clkEn && !rom_r && bWe_r && bBe_r == `ERB_B_BE_RST && aWe_r
		&& aBe_r == `ERB_A_BE_RST && aAddr_r != bAddr_r[7:1])
		|=> bFlowData == $past(bData_r) && aFlowData == $past(aData_r))
		else $error("Second write port failed during a dual write.");

	c_dual_write: cover property (@(posedge mclk)
		clkEn && aWe_r && bWe_r && !rom_r);
	c_collision: cover property (@(posedge mclk)
		clkEn && aWe_r && !bWe_r && aAddr_r == bAddr_r[7:1]);
	c_aclr: cover property (@(posedge mclk) outAclr && !clr);
	c_gated: cover property (@(posedge mclk) !clkEn ##1 !clkEn ##1 clkEn);

endmodule
`default_nettype wire

//--- test_embedded_ram_block.sv
// Purpose: Self-checking bench for the embedded RAM block.
// Assumes: Inputs change by non-blocking assignment after rising edges.
// Notes:   Flow data is checked two edges after a request, pipe one later.
`timescale 1ns/1ps
`default_nettype none

module test_embedded_ram_block;
	logic                 mclk, reset, chip_wide_clear_n, outAclr;
	logic                 clkEn, romMode, aWrEn, bWrEn;
	erb_pkg::erb_a_addr_t aAddr;
	erb_pkg::erb_a_word_t aWrData, aFlowData, aPipeData, par;
	erb_pkg::erb_a_be_t   aByteEn;
	erb_pkg::erb_b_addr_t bAddr;
	erb_pkg::erb_b_word_t bWrData, bFlowData, bPipeData;
	erb_pkg::erb_b_be_t   bByteEn;
	int                   failures, samples_checked, cyc;

	erb_ram_block dut_u (.mclk(mclk), .reset(reset),
		.chip_wide_clear_n(chip_wide_clear_n), .outAclr(outAclr),
		.clkEn(clkEn), .romMode(romMode), .aAddr(aAddr),
		.aWrData(aWrData), .aWrEn(aWrEn), .aByteEn(aByteEn),
		.bAddr(bAddr), .bWrData(bWrData), .bWrEn(bWrEn),
		.bByteEn(bByteEn), .aFlowData(aFlowData), .aPipeData(aPipeData),
		.bFlowData(bFlowData), .bPipeData(bPipeData));
	erb_fabric_parity fab_u (.payload(32'h12345678), .stored(par));

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task tick(); @(posedge mclk); endtask
	task nxt(); tick(); @(negedge mclk); endtask
	task idle(); aWrEn <= 1'b0; bWrEn <= 1'b0; endtask
	task wait2(); tick(); idle(); nxt(); endtask

	task opA(input logic w, input erb_pkg::erb_a_be_t be,
		input erb_pkg::erb_a_addr_t ad, input erb_pkg::erb_a_word_t d);
		aWrEn <= w; aByteEn <= be; aAddr <= ad; aWrData <= d;
	endtask

	task opB(input logic w, input erb_pkg::erb_b_be_t be,
		input erb_pkg::erb_b_addr_t ad, input erb_pkg::erb_b_word_t d);
		bWrEn <= w; bByteEn <= be; bAddr <= ad; bWrData <= d;
	endtask

	task chkA(input erb_pkg::erb_a_word_t got, input erb_pkg::erb_a_word_t e);
		samples_checked++;
		if (got !== e) begin
			failures++;
			$display("[ERR] %0t port A got %h want %h", $time, got, e);
		end
	endtask

	task chkB(input erb_pkg::erb_b_word_t got, input erb_pkg::erb_b_word_t e);
		samples_checked++;
		if (got !== e) begin
			failures++;
			$display("[ERR] %0t port B got %h want %h", $time, got, e);
		end
	endtask

	task complete_run();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{failures, samples_checked, cyc} = '0;
		{reset, chip_wide_clear_n, outAclr, clkEn, romMode} = 5'h1A;
		opA(1'b0, 4'hF, 7'h00, 36'h0);
		opB(1'b0, 2'h3, 8'h00, 18'h0);
		repeat (12) tick();
		reset <= 1'b0;
		tick();
		@(negedge mclk);
		chkA(aPipeData, 36'h0);
		chkB(bPipeData, 18'h0);
		tick();
		opA(1'b0, 4'hF, 7'h05, 36'h0);
		opB(1'b0, 2'h3, 8'h0A, 18'h0);
		wait2();
		chkA(aFlowData, 36'h5);
		chkB(bFlowData, 18'h5);
		nxt();
		chkA(aPipeData, 36'h5);
		chkB(bPipeData, 18'h5);
		$display("test init done");
		tick();
		opA(1'b1, 4'hF, 7'h03, par);
		opB(1'b0, 2'h3, 8'h07, 18'h0);
		wait2();
		chkA(aFlowData, par);
		chkB(bFlowData, 18'h0);
		tick();
		opA(1'b1, 4'h5, 7'h03, 36'hFFFFFFFFF);
		opB(1'b0, 2'h3, 8'h06, 18'h0);
		wait2();
		chkA(aFlowData, (par & 36'hFF803FE00) | 36'h007FC01FF);
		chkB(bFlowData, par[17:0]);
		tick();
		opB(1'b1, 2'h2, 8'h15, 18'h2AAAA);
		opA(1'b0, 4'hF, 7'h0A, 36'h0);
		wait2();
		chkA(aFlowData, 36'hA);
		chkB(bFlowData, 18'h2AA00);
		tick();
		opA(1'b0, 4'hF, 7'h0A, 36'h0);
		wait2();
		chkA(aFlowData, 36'hAA800000A);
		$display("test byte lanes done");
		tick();
		opA(1'b1, 4'hF, 7'h14, 36'h123456789);
		opB(1'b1, 2'h3, 8'h00, 18'h3FFFF);
		tick();
		opA(1'b0, 4'hF, 7'h00, 36'h0);
		opB(1'b0, 2'h3, 8'h28, 18'h0);
		wait2();
		chkA(aFlowData, 36'h00003FFFF);
		chkB(bFlowData, 18'h16789);
		tick();
		clkEn <= 1'b0;
		opA(1'b1, 4'hF, 7'h00, 36'h0);
		repeat (3) tick();
		@(negedge mclk);
		chkA(aFlowData, 36'h00003FFFF);
		tick();
		clkEn <= 1'b1;
		opA(1'b0, 4'hF, 7'h00, 36'h0);
		wait2();
		chkA(aFlowData, 36'h00003FFFF);
		tick();
		romMode <= 1'b1;
		opA(1'b1, 4'hF, 7'h05, 36'hFFFFFFFFF);
		opB(1'b0, 2'h3, 8'h0A, 18'h0);
		tick();
		romMode <= 1'b0;
		opA(1'b0, 4'hF, 7'h05, 36'h0);
		nxt();
		nxt();
		chkA(aFlowData, 36'h5);
		$display("test enables done");
		tick();
		outAclr <= 1'b1;
		@(negedge mclk);
		chkA(aPipeData, 36'h0);
		chkB(bPipeData, 18'h0);
		chkA(aFlowData, 36'h5);
		tick();
		outAclr <= 1'b0;
		chip_wide_clear_n <= 1'b0;
		tick();
		chip_wide_clear_n <= 1'b1;
		@(negedge mclk);
		chkA(aFlowData, 36'h0);
		chkB(bFlowData, 18'h0);
		$display("test clears done");
		complete_run();
	end
endmodule
`default_nettype wire
